// File: design/meas_if.sv
// Interval timer carrier between sequencer and timer
`timescale 1ns/1ns
`default_nettype none
interface meas_if;
  logic load;
  logic [31:0] count;
  logic done;
  // Sequencer side
  modport ctrl (output load, output count, input done);
  // Timer side
  modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

// File: design/meas_timer.sv
// Down-counting interval timer, done pulses count cycles after load
`timescale 1ns/1ns
`default_nettype none
module meas_timer #(
  parameter int unsigned RST_COUNT = 32'h00000001
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  meas_if.tmr t
);
  logic [31:0] cnt_r;

  // Reset value arms the first interval without a load
  assign t.done = (cnt_r == 32'h00000001);

  // Count down and park at zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= RST_COUNT;
    end else if (t.load) begin
      cnt_r <= t.count;
    end else if (cnt_r != 32'h00000000) begin
      cnt_r <= cnt_r - 32'h00000001;
    end
  end
endmodule
`default_nettype wire

// File: design/ocv_defines.svh
// Offsets, field positions, reset values and timing figures of the measurement sequencer
`ifndef OCV_DEFINES_SVH
`define OCV_DEFINES_SVH

// ============================================================
// Register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_DCAP 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_MASK 8'h0C
`define ADDR_CALC_V 8'h10
`define ADDR_CALC_I 8'h14
`define ADDR_CALC_T 8'h18

// ============================================================
// Field positions
`define CTRL_CMD 0
`define CTRL_BI 1
`define CTRL_SLEEP 2
`define STS_DONE 0
`define STS_FAIL 1
`define STS_PASS 2
`define STS_BUSY 8
`define STS_QUAL 9

// ============================================================
// Reset values
`define DCAP_RST 16'h03E8
`define MASK_RST 3'h0
`define STS_RST 3'h0

// ============================================================
// Timing, in milliseconds, the clock rate in cycles per millisecond, and the capacity divider for the fail threshold
`define CLK_PER_MS 100000
`define QUAL_MS 165
`define CUR_MS 1000
`define VOLT_MS 125
`define TEMP_MS 125
`define ACT_INT_MS 1000
`define SLEEP_INT_MS 20000
`define POR_DLY_MS 300
`define CAP_DIV 16'h0012

`endif

// File: design/ocv_measure_sequencer.sv
// Open-circuit-voltage measurement sequencer with APB registers
`timescale 1ns/1ns
`default_nettype none
`include "ocv_defines.svh"
module ocv_measure_sequencer #(
  parameter int unsigned QUAL_CYC = `QUAL_MS * `CLK_PER_MS,
  parameter int unsigned CUR_CYC = `CUR_MS * `CLK_PER_MS,
  parameter int unsigned VOLT_CYC = `VOLT_MS * `CLK_PER_MS,
  parameter int unsigned TEMP_CYC = `TEMP_MS * `CLK_PER_MS,
  parameter int unsigned ACT_CYC = `ACT_INT_MS * `CLK_PER_MS,
  parameter int unsigned SLEEP_CYC = `SLEEP_INT_MS * `CLK_PER_MS,
  parameter int unsigned POR_CYC = `POR_DLY_MS * `CLK_PER_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter results, same clock domain
  input wire logic [15:0] adc_current_avg,
  input wire logic [15:0] adc_voltage,
  input wire logic [15:0] adc_temp,
  input wire logic [15:0] adc_inst_current,
  input wire logic adc_inst_valid,
  // Measurement windows to the converter
  output logic current_sample_period,
  output logic voltage_sample_period,
  output logic temperature_sample_period,
  output logic qualify_interval_alias,
  // Qualified set to the calculation
  output logic calc_start,
  output logic [15:0] calc_voltage,
  output logic [15:0] calc_current,
  output logic [15:0] calc_temp,
  // Interrupt
  output logic irq
);
  localparam int unsigned GAP_CYC = SLEEP_CYC - ACT_CYC;

  meas_if tif ();
  ocv_pkg::state_t state_r, state_nxt;
  logic [31:0] set_cnt_r;
  logic bi_pending_r, last_valid_r, fail_seen_r, sleep_r, calc_start_r;
  logic [15:0] dcap_r;
  logic [2:0] sts_r, mask_r;
  logic [31:0] prdata_r;
  logic [15:0] set_v_r, set_t_r;
  logic [15:0] last_v_r, last_i_r, last_t_r;
  logic [15:0] qual_v_r, qual_i_r, qual_t_r;
  logic [15:0] calc_v_r, calc_i_r, calc_t_r;

  // Address map check, used by strobes and error answer
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == `ADDR_CTRL) || (a == `ADDR_DCAP) || (a == `ADDR_STATUS) ||
                  (a == `ADDR_MASK) || (a == `ADDR_CALC_V) || (a == `ADDR_CALC_I) ||
                  (a == `ADDR_CALC_T);
  endfunction

  // ============================================================
  // APB decode
  wire access = psel && penable;
  wire setup = psel && !penable;
  wire wr_en = access && pwrite && addr_mapped(paddr);
  wire ctrl_wr = wr_en && (paddr == `ADDR_CTRL);
  wire dcap_wr = wr_en && (paddr == `ADDR_DCAP);
  wire sts_wr = wr_en && (paddr == `ADDR_STATUS);
  wire mask_wr = wr_en && (paddr == `ADDR_MASK);
  wire cmd_wr = ctrl_wr && pwdata[`CTRL_CMD];
  wire bi_wr = ctrl_wr && pwdata[`CTRL_BI];

  // Zero wait states keep the bus answer fixed at one access cycle
  assign pready = 1'b1;
  assign pslverr = access && !addr_mapped(paddr);
  assign prdata = prdata_r;

  // ============================================================
  // Sequencing decode
  wire in_set = (state_r == ocv_pkg::ST_SET);
  wire in_qual = (state_r == ocv_pkg::ST_QUAL);
  wire set_end = in_set && (set_cnt_r == CUR_CYC - 1);
  wire volt_end = in_set && (set_cnt_r == VOLT_CYC - 1);
  wire temp_end = in_set && (set_cnt_r == VOLT_CYC + TEMP_CYC - 1);
  // A command before any complete set has nothing to qualify, so it waits for none
  wire cmd_go = cmd_wr && last_valid_r && (in_set || state_r == ocv_pkg::ST_GAP);
  wire bi_go = bi_wr && !in_qual;
  wire bi_qual = set_end && bi_pending_r && !cmd_go;
  wire go_qual = cmd_go || bi_qual;
  wire go_gap = set_end && !bi_pending_r && sleep_r && !cmd_go && !bi_go;
  wire qual_end = in_qual && tif.done;
  wire restart = (state_nxt == ocv_pkg::ST_SET) && (!in_set || set_end || bi_go);

  // Signed current folded to magnitude before the compare
  wire [16:0] inst_abs = adc_inst_current[15] ?
                         (17'h00000 - {adc_inst_current[15], adc_inst_current}) :
                         {1'b0, adc_inst_current};
  wire [15:0] fail_thr = dcap_r / `CAP_DIV;
  wire fail_hit = in_qual && adc_inst_valid && (inst_abs >= {1'b0, fail_thr});
  wire fail_any = fail_seen_r || fail_hit;

  // Status flags: hardware set beats a write-one clear in the same cycle
  wire [2:0] sts_set = {qual_end && !fail_any, qual_end && fail_any, qual_end};
  wire [2:0] sts_clr = sts_wr ? pwdata[2:0] : 3'h0;
  wire [2:0] sts_nxt = (sts_r & ~sts_clr) | sts_set;

  // Timer loads: qualification window or sleep gap
  assign tif.load = go_qual || go_gap;
  assign tif.count = go_qual ? QUAL_CYC : GAP_CYC;

  // Windows toward the converter, calculation outputs and interrupt
  assign current_sample_period = in_set;
  assign voltage_sample_period = in_set && (set_cnt_r < VOLT_CYC);
  assign temperature_sample_period = in_set && (set_cnt_r >= VOLT_CYC) &&
                                     (set_cnt_r < VOLT_CYC + TEMP_CYC);
  assign qualify_interval_alias = in_qual;
  assign calc_start = calc_start_r;
  assign calc_voltage = calc_v_r;
  assign calc_current = calc_i_r;
  assign calc_temp = calc_t_r;
  assign irq = |(sts_r & mask_r);

  meas_timer #(
    .RST_COUNT(POR_CYC)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .t(tif.tmr)
  );

  // ============================================================
  // Next phase
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ocv_pkg::ST_POR_WAIT: begin
        if (tif.done) begin
          state_nxt = ocv_pkg::ST_SET;
        end
      end
      ocv_pkg::ST_SET: begin
        if (go_qual) begin
          state_nxt = ocv_pkg::ST_QUAL;
        end else if (go_gap) begin
          state_nxt = ocv_pkg::ST_GAP;
        end
      end
      ocv_pkg::ST_GAP: begin
        if (cmd_go) begin
          state_nxt = ocv_pkg::ST_QUAL;
        end else if (bi_go || tif.done) begin
          state_nxt = ocv_pkg::ST_SET;
        end
      end
      default: begin
        if (tif.done) begin
          state_nxt = ocv_pkg::ST_SET;
        end
      end
    endcase
  end

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (paddr == `ADDR_CTRL) begin
      rd_mux[`CTRL_SLEEP] = sleep_r;
    end else if (paddr == `ADDR_DCAP) begin
      rd_mux[15:0] = dcap_r;
    end else if (paddr == `ADDR_STATUS) begin
      rd_mux[2:0] = sts_r;
      rd_mux[`STS_BUSY] = in_qual || bi_pending_r;
      rd_mux[`STS_QUAL] = in_qual;
    end else if (paddr == `ADDR_MASK) begin
      rd_mux[2:0] = mask_r;
    end else if (paddr == `ADDR_CALC_V) begin
      rd_mux[15:0] = calc_v_r;
    end else if (paddr == `ADDR_CALC_I) begin
      rd_mux[15:0] = calc_i_r;
    end else if (paddr == `ADDR_CALC_T) begin
      rd_mux[15:0] = calc_t_r;
    end
  end

  // ============================================================
  // Registers software owns
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dcap_r <= `DCAP_RST;
      mask_r <= `MASK_RST;
      sts_r <= `STS_RST;
      sleep_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      if (dcap_wr) dcap_r <= pwdata[15:0];
      if (mask_wr) mask_r <= pwdata[2:0];
      if (ctrl_wr) sleep_r <= pwdata[`CTRL_SLEEP];
      sts_r <= sts_nxt;
      if (setup) prdata_r <= rd_mux; // Read data settles before the access cycle
    end
  end

  // Phase, set counter and pending insert
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ocv_pkg::ST_POR_WAIT;
      set_cnt_r <= 32'h00000000;
      bi_pending_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      set_cnt_r <= restart ? 32'h00000000 : (in_set ? set_cnt_r + 32'h00000001 : set_cnt_r);
      if (bi_go) begin
        bi_pending_r <= 1'b1;
      end else if (bi_qual) begin
        bi_pending_r <= 1'b0;
      end
    end
  end

  // Set capture: voltage, temperature and averaged current at their window ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      set_v_r <= 16'h0000;
      set_t_r <= 16'h0000;
      last_v_r <= 16'h0000;
      last_i_r <= 16'h0000;
      last_t_r <= 16'h0000;
      last_valid_r <= 1'b0;
    end else begin
      if (volt_end) set_v_r <= adc_voltage;
      if (temp_end) set_t_r <= adc_temp;
      if (set_end) begin
        last_v_r <= set_v_r;
        last_i_r <= adc_current_avg;
        last_t_r <= set_t_r;
        last_valid_r <= 1'b1;
      end
    end
  end

  // Set under qualification, and its hand-off to the calculation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qual_v_r <= 16'h0000;
      qual_i_r <= 16'h0000;
      qual_t_r <= 16'h0000;
      calc_v_r <= 16'h0000;
      calc_i_r <= 16'h0000;
      calc_t_r <= 16'h0000;
      fail_seen_r <= 1'b0;
      calc_start_r <= 1'b0;
    end else begin
      if (cmd_go) begin
        qual_v_r <= last_v_r;
        qual_i_r <= last_i_r;
        qual_t_r <= last_t_r;
      end else if (bi_qual) begin
        qual_v_r <= set_v_r;
        qual_i_r <= adc_current_avg;
        qual_t_r <= set_t_r;
      end
      fail_seen_r <= go_qual ? 1'b0 : (fail_seen_r || fail_hit);
      calc_start_r <= qual_end && !fail_any;
      if (qual_end && !fail_any) begin
        calc_v_r <= qual_v_r;
        calc_i_r <= qual_i_r;
        calc_t_r <= qual_t_r;
      end
    end
  end

  // ============================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_FAIL_IN_WINDOW: assert property ($rose(sts_r[`STS_FAIL]) |-> $past(in_qual))
    else $error("fail flag rose outside the qualification window");
  AST_FAIL_THRESHOLD: assert property (fail_hit |=>
                                       (in_qual && fail_seen_r) || sts_r[`STS_FAIL])
    else $error("over-threshold current did not set the fail flag");
  AST_FAIL_HOLD: assert property (qual_end && fail_seen_r |=> sts_r[`STS_FAIL])
    else $error("earlier over-threshold sample did not set the fail flag");
  AST_PASS_CALC: assert property (calc_start |-> $past(qual_end) && !$past(fail_any))
    else $error("calculation started without a passing window");
  AST_CUR_LEN: assert property ($fell(current_sample_period) && !rst |->
                                $past(set_cnt_r) == CUR_CYC - 1 || $past(bi_go || cmd_go))
    else $error("current window length wrong");
  AST_VOLT_LEN: assert property ($fell(voltage_sample_period) && $past(in_set) && in_set |->
                                 set_cnt_r == VOLT_CYC)
    else $error("voltage window length wrong");
  AST_TEMP_LEN: assert property ($fell(temperature_sample_period) && in_set && !$past(bi_go) |->
                                 set_cnt_r == VOLT_CYC + TEMP_CYC)
    else $error("temperature window length wrong");
  AST_QUAL_CAUSE: assert property ($rose(qualify_interval_alias) |->
                                   $past(cmd_go) || $past(bi_qual))
    else $error("qualification started without command or insert");
  AST_POR_INSERT: assert property ($past(rst) |-> bi_pending_r &&
                                   state_r == ocv_pkg::ST_POR_WAIT)
    else $error("reset did not raise an insert event");
  AST_INSERT_SEQ: assert property (bi_qual |=> in_qual && qual_v_r == $past(set_v_r))
    else $error("insert did not qualify the fresh set");
  AST_CMD_SET: assert property (cmd_go |=> in_qual && qual_i_r == $past(last_i_r))
    else $error("command did not use the latest set");
  AST_SLEEP_GAP: assert property (go_gap |-> tif.count == SLEEP_CYC - ACT_CYC)
    else $error("sleep interval wrong");
  AST_DONE_FLAG: assert property (qual_end |=> sts_r[`STS_DONE] && in_set)
    else $error("done flag not set at measurement end");

  COV_PASS: cover property (qual_end && !fail_any ##1 calc_start);
  COV_FAIL: cover property (fail_hit ##[1:20] qual_end);
  COV_CMD: cover property (cmd_go ##1 in_qual);
  COV_SLEEP: cover property (go_gap ##1 state_r == ocv_pkg::ST_GAP);
endmodule
`default_nettype wire

// File: design/ocv_pkg.sv
// Types shared by the measurement sequencer
package ocv_pkg;
  // Sequencer phases
  typedef enum logic [1:0] {
    ST_POR_WAIT = 2'b00,
    ST_SET = 2'b01,
    ST_GAP = 2'b10,
    ST_QUAL = 2'b11
  } state_t;
endpackage

// File: testbench/adc_model.sv
// Converter model that feeds the sequencer its results
`timescale 1ns/1ns
`default_nettype none
module adc_model (
  // Clock
  input wire logic clk,
  // Values set by the bench, and the sequencer's qualification window
  input wire logic [15:0] v_set,
  input wire logic [15:0] i_set,
  input wire logic qwin,
  // Converter results
  output logic [15:0] cur_avg,
  output logic [15:0] volt,
  output logic [15:0] temp,
  output logic [15:0] inst,
  output logic inst_vld
);
  // ==========
  // Results
  logic [1:0] ph = 2'h0;
  // Free-running phase, so samples land at varying window offsets
  always @(posedge clk) ph <= ph + 2'h1;
  // Steady averages; temperature offset from voltage to tell them apart
  assign cur_avg = i_set;
  assign volt = v_set;
  assign temp = v_set ^ 16'h00FF;
  // Sparse samples inside the window only; junk between them
  assign inst_vld = qwin && ph == 2'h0;
  assign inst = inst_vld ? i_set : ~i_set;
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the measurement sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ==========
  // Signals
  localparam int QC = 20, CC = 40, VC = 8, TC = 8, SC = 100, PC = 10;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, irq, cstart, a_vld;
  logic [15:0] v_set = 16'h1234, i_set = 16'h0005, a_cur, a_v, a_t, a_i, c_v, c_i, c_t;
  logic [15:0] ival[4] = '{16'h0063, 16'h0064, 16'hFF9C, 16'hFF9D};
  logic ifail[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  wire logic [3:0] w;
  int run[4] = '{0, 0, 0, 0};
  int len[4] = '{0, 0, 0, 0};
  int since = 0, per = 0, nqual = 0, nstart = 0, cyc = 0, n_errors = 0, check_count = 0;
  logic w1_d = 1'b0, w3_d = 1'b0;

  // Clock
  always #5 clk = ~clk;

  // ==========
  // Design and converter
  ocv_measure_sequencer #(.QUAL_CYC(QC), .CUR_CYC(CC), .VOLT_CYC(VC), .TEMP_CYC(TC),
    .ACT_CYC(CC), .SLEEP_CYC(SC), .POR_CYC(PC)) uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_current_avg(a_cur), .adc_voltage(a_v), .adc_temp(a_t), .adc_inst_current(a_i),
    .adc_inst_valid(a_vld), .current_sample_period(w[0]), .voltage_sample_period(w[1]),
    .temperature_sample_period(w[2]), .qualify_interval_alias(w[3]), .calc_start(cstart),
    .calc_voltage(c_v), .calc_current(c_i), .calc_temp(c_t), .irq(irq));
  adc_model am (.clk(clk), .v_set(v_set), .i_set(i_set), .qwin(w[3]), .cur_avg(a_cur),
    .volt(a_v), .temp(a_t), .inst(a_i), .inst_vld(a_vld));

  // ==========
  // Window lengths, set spacing by voltage window rise, counts, timeout
  always @(posedge clk) begin
    for (int k = 0; k < 4; k++) begin
      if (w[k] === 1'b1) begin
        run[k] <= run[k] + 1;
      end else if (run[k] != 0) begin
        len[k] <= run[k];
        run[k] <= 0;
      end
    end
    since <= since + 1;
    w1_d <= w[1];
    w3_d <= w[3];
    if (w[1] === 1'b1 && w1_d !== 1'b1) begin
      per <= since;
      since <= 1;
    end
    if (w[3] === 1'b1 && w3_d !== 1'b1) nqual <= nqual + 1;
    if (cstart === 1'b1) nstart <= nstart + 1;
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  // ==========
  // Tasks
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rdat, e);
  endtask
  // Bounded wait for a window level; a miss shows up in later checks
  task wt(input int k, input logic v);
    int i;
    for (i = 0; i < 400 && w[k] !== v; i++) @(posedge clk);
  endtask
  task close_out();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========
  // Tests
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // Reset values; insert pending shows as busy
    rd(8'h04, 32'h3E8, "dcap");
    rd(8'h0C, 32'h0, "mask");
    rd(8'h00, 32'h0, "ctrl");
    rd(8'h08, 32'h100, "status_por");
    $display("test reset done");
    // Power-on: full set, then qualification on that fresh set
    wt(3, 1'b1);
    wt(3, 1'b0);
    repeat (2) @(posedge clk);
    chk("cur_len", len[0], CC);
    chk("volt_len", len[1], VC);
    chk("temp_len", len[2], TC);
    chk("qual_len", len[3], QC);
    rd(8'h08, 32'h5, "status_pass");
    chk("calc_v", {16'h0, c_v}, 32'h1234);
    rd(8'h14, 32'h5, "calc_i");
    rd(8'h18, 32'h12CB, "calc_t");
    chk("calc_i_out", {16'h0, c_i}, 32'h5);
    chk("calc_t_out", {16'h0, c_t}, 32'h12CB);
    chk("starts", nstart, 1);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    $display("test power-on done");
    // Mask, raise and clear the interrupt
    apb(1'b1, 8'h0C, 32'h4);
    @(negedge clk);
    chk("irq_on", {31'h0, irq}, 32'h1);
    apb(1'b1, 8'h08, 32'h4);
    @(negedge clk);
    chk("irq_off", {31'h0, irq}, 32'h0);
    rd(8'h08, 32'h1, "status_w1c");
    apb(1'b1, 8'h08, 32'h1);
    $display("test irq done");
    // Threshold 100: both signs, one below and at the limit
    apb(1'b1, 8'h04, 32'h708);
    apb(1'b1, 8'h0C, 32'h2);
    for (int n = 0; n < 4; n++) begin
      i_set <= ival[n];
      apb(1'b1, 8'h00, 32'h1);
      wt(3, 1'b1);
      wt(3, 1'b0);
      @(negedge clk);
      chk("irq_fail", {31'h0, irq}, {31'h0, ifail[n]});
      rd(8'h08, ifail[n] ? 32'h3 : 32'h5, "status_thr");
      apb(1'b1, 8'h08, 32'h7);
    end
    chk("starts_thr", nstart, 3);
    repeat (100) @(posedge clk);
    chk("quals", nqual, 5);
    $display("test threshold done");
    // Command inside a set uses the set before it
    i_set <= 16'h0;
    v_set <= 16'h1111;
    wt(1, 1'b1);
    wt(1, 1'b0);
    wt(1, 1'b1);
    v_set <= 16'h2222;
    apb(1'b1, 8'h00, 32'h1);
    wt(3, 1'b1);
    wt(3, 1'b0);
    repeat (2) @(posedge clk);
    chk("calc_v_last", {16'h0, c_v}, 32'h1111);
    apb(1'b1, 8'h08, 32'h7);
    wt(1, 1'b1);
    wt(1, 1'b0);
    wt(1, 1'b1);
    @(negedge clk);
    chk("act_period", per, CC);
    // Sleep spacing between sets
    apb(1'b1, 8'h00, 32'h4);
    rd(8'h00, 32'h4, "ctrl_sleep");
    wt(1, 1'b0);
    wt(1, 1'b1);
    wt(1, 1'b0);
    wt(1, 1'b1);
    @(negedge clk);
    chk("sleep_period", per, SC);
    // Insert event while sleeping
    apb(1'b1, 8'h00, 32'h6);
    wt(3, 1'b1);
    apb(1'b1, 8'h00, 32'h5);
    wt(3, 1'b0);
    repeat (2) @(posedge clk);
    rd(8'h08, 32'h5, "status_insert");
    $display("test sequencing done");
    // Unmapped address and read-only result
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", {31'h0, rerr}, 32'h1);
    chk("unmapped_data", rdat, 32'h0);
    apb(1'b1, 8'h10, 32'hFFFF);
    rd(8'h10, 32'h2222, "calc_ro");
    chk("quals_all", nqual, 7);
    $display("test refusals done");
    close_out();
  end
endmodule
`default_nettype wire
